// ==== bench/tb.sv ====
// self-checking bench for the host and modem pin logic
`timescale 1ns/10ps
`default_nettype none
module tb;
	import uhm_pkg::*;
	logic clk, reset, mr, s1, s2, s3n, as_n, fifo, run, rclk, rclk_q, live;
	logic [3:0] evt, half;
	logic [2:0] lvl;
	uhm_bus_req_t req;
	uhm_modem_in_t mdm;
	logic [7:0] dout, v;
	logic oe_n, toff, irq, dtr_n, p1_n, p2_n, txa, tick;
	logic [7:0] q[$];
	int bad_count, checks, edges, ticks;
	uhm_pins dut_u (.clk(clk), .reset(reset), .master_reset_in(mr), .select_high_first(s1),
		.select_high_second(s2), .select_low_third(s3n), .address_latch_strobe_n(as_n), .bus_req(req),
		.modem_in(mdm), .rclk_16x(rclk), .rx_error_evt(evt[0]), .rx_data_evt(evt[1]),
		.rx_timeout_evt(evt[2]), .thr_empty_evt(evt[3]), .fifo_mode(fifo), .data_out(dout),
		.data_oe_n(oe_n), .transceiver_off(toff), .irq(irq), .dtr_n(dtr_n), .user_pin_one_n(p1_n),
		.user_pin_two_n(p2_n), .tx_allowed(txa), .rx_sample_tick(tick));
	uhm_modem_model mdl_u (.clk(clk), .assert_lvl(lvl), .rclk_run(run), .rclk_half(half),
		.modem_out(mdm), .rclk_out(rclk));
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stop_test();
		if (bad_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic bus(logic [2:0] a, logic [7:0] d, logic w, logic r);
		@(posedge clk);
		req <= '{a, d, w, r};
		@(posedge clk);
		req.wr <= 1'b0;
		req.rd <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [2:0] a, logic [7:0] e);
		q.push_back(e);
		bus(a, 8'h00, 1'b0, 1'b1);
	endtask
	task automatic wt(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pins(logic [2:0] e);
		chk("dtr and user pins", {5'h0, e}, {5'h0, dtr_n, p1_n, p2_n});
	endtask
	task automatic pulse(logic [3:0] e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= 4'h0;
	endtask
	// reads are matched in order as the bus turns round
	always @(posedge clk) begin
		rclk_q <= rclk;
		if (rclk && !rclk_q) edges++;
		if (tick === 1'b1) ticks++;
		if (live) begin
			chk("transceiver_off", {7'h00, ~oe_n}, {7'h00, toff});
			if (oe_n === 1'b0) chk("read data", q.size() ? q.pop_front() : 8'hee, dout);
		end
	end
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		stop_test();
	end
	initial begin
		void'($urandom(32'h49d9));
		{reset, mr, s1, s2, s3n, as_n, fifo, run, rclk_q, live} = 10'b1011000000;
		{evt, half, lvl} = 11'h000;
		req = '0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		live <= 1'b1;
		wt(1);
		pins(3'h7);
		rd(ADDR_MCR, 8'h00);
		rd(3'h7, 8'h00);
		run <= 1'b1;
		repeat (6) begin
			v = 8'($urandom) & 8'h0f;
			bus(ADDR_MCR, v, 1'b1, 1'b0);
			pins(~{v[0], v[2], v[3]});
			rd(ADDR_MCR, v);
		end
		bus(ADDR_MCR, 8'h1d, 1'b1, 1'b0);
		pins(3'h7);
		bus(ADDR_MCR, 8'h00, 1'b1, 1'b0);
		// a deselected read must not turn the bus round
		for (int c = 0; c < 3; c++) begin
			{s1, s2, s3n} <= 3'b110 ^ (3'h1 << c);
			bus(ADDR_MCR, 8'h0d, 1'b1, 1'b0);
			bus(ADDR_MCR, 8'h00, 1'b0, 1'b1);
			pins(3'h7);
		end
		{s1, s2, s3n} <= 3'b110;
		wt(1);
		as_n <= 1'b1;
		wt(1);
		{s1, s2, s3n} <= 3'b001;
		bus(ADDR_MCR, 8'h01, 1'b1, 1'b0);
		pins(3'h3);
		{s1, s2, s3n, as_n} <= 4'b1100;
		bus(ADDR_MASK, 8'h1f, 1'b1, 1'b0);
		for (int i = 0; i < 3; i++) begin
			lvl[i] <= 1'b1;
			wt(4);
			chk("irq", 8'h01, 8'(irq));
			rd(ADDR_MSR, {lvl[2], 1'b0, lvl[1], lvl[0], 4'h0} | (8'h01 << (i + (i == 2))));
			rd(ADDR_MSR, {lvl[2], 1'b0, lvl[1], lvl[0], 4'h0});
			rd(ADDR_IRQ, 8'h10);
			wt(2);
			chk("irq", 8'h00, 8'(irq));
		end
		bus(ADDR_MASK, 8'h0f, 1'b1, 1'b0);
		lvl[0] <= 1'b0;
		wt(4);
		chk("irq", 8'h00, 8'(irq));
		rd(ADDR_MSR, 8'ha1);
		rd(ADDR_IRQ, 8'h10);
		bus(ADDR_MCR, 8'h20, 1'b1, 1'b0);
		wt(1);
		chk("tx_allowed", 8'h00, 8'(txa));
		lvl[0] <= 1'b1;
		wt(4);
		chk("tx_allowed", 8'h01, 8'(txa));
		rd(ADDR_IRQ, 8'h00);
		rd(ADDR_MSR, 8'hb1);
		bus(ADDR_MCR, 8'h00, 1'b1, 1'b0);
		half <= 4'h5;
		for (int k = 0; k < 5; k++) begin
			fifo <= (k == 4);
			pulse((k == 4) ? 4'h4 : 4'h1 << k);
			wt(2);
			chk("irq", 8'(k != 2), 8'(irq));
			rd(ADDR_IRQ, (k == 2) ? 8'h00 : (k == 4) ? 8'h04 : 8'h01 << k);
		end
		run <= 1'b0;
		wt(8);
		chk("rclk ticks", 8'(edges), 8'(ticks));
		bus(ADDR_MCR, 8'h0d, 1'b1, 1'b0);
		pulse(4'h8);
		mr <= 1'b1;
		wt(2);
		pins(3'h7);
		chk("irq", 8'h00, 8'(irq));
		mr <= 1'b0;
		rd(ADDR_MCR, 8'h00);
		wt(2);
		chk("pending reads", 8'h00, 8'(q.size()));
		stop_test();
	end
endmodule
`default_nettype wire

// ==== bench/uhm_modem_model.sv ====
// far-side modem model: modem levels and receiver clock
`timescale 1ns/10ps
`default_nettype none
module uhm_modem_model (
	input wire logic clk,
	input wire logic [2:0] assert_lvl,
	input wire logic rclk_run,
	input wire logic [3:0] rclk_half,
	output uhm_pkg::uhm_modem_in_t modem_out,
	output logic rclk_out
);
	import uhm_pkg::*;
	logic [3:0] cnt_q;
	initial begin
		modem_out = 3'b111;
		rclk_out = 1'b0;
		cnt_q = 4'h0;
	end
	// levels are active low and land one cycle after a request
	always @(posedge clk) begin
		modem_out <= ~assert_lvl;
		// clock stands still while stopped, so no stray edge
		if (!rclk_run) begin
			cnt_q <= 4'h0;
			rclk_out <= 1'b0;
		end else if (cnt_q == rclk_half) begin
			cnt_q <= 4'h0;
			rclk_out <= ~rclk_out;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ==== shared/uhm_pkg.sv ====
// constants and carrier types for the host and modem pin logic
package uhm_pkg;
	localparam logic [2:0] ADDR_MASK = 3'h1;
	localparam logic [2:0] ADDR_IRQ = 3'h2;
	localparam logic [2:0] ADDR_MCR = 3'h4;
	localparam logic [2:0] ADDR_MSR = 3'h6;
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_USER_PIN_ONE = 2;
	localparam int MCR_USER_PIN_TWO = 3;
	localparam int MCR_LOOP = 4;
	localparam int MCR_ACTS = 5;
	localparam int MSR_DCTS = 0;
	localparam int MSR_DDSR = 1;
	localparam int MSR_DRI = 2;
	localparam int MSR_DDCD = 3;
	localparam int MSR_CTS = 4;
	localparam int MSR_DSR = 5;
	localparam int MSR_RI = 6;
	localparam int MSR_DCD = 7;
	localparam int IRQ_W = 5;
	localparam int IRQ_RXERR = 0;
	localparam int IRQ_RXDAT = 1;
	localparam int IRQ_RXTO = 2;
	localparam int IRQ_THRE = 3;
	localparam int IRQ_MODEM = 4;
	localparam logic [7:0] MCR_RST = 8'h00;
	localparam logic [IRQ_W-1:0] MASK_RST = 5'h00;
	localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} uhm_bus_req_t;
	typedef struct packed {
		logic dcd_n;
		logic dsr_n;
		logic cts_n;
	} uhm_modem_in_t;
endpackage

// ==== src/uhm_pins.sv ====
// host bus and modem pin logic of the serial controller
// Contract
// RULE1: selected only with first, second high, third low
// RULE2: strobe low passes selects, high holds them
// RULE3: status bit 4 shows clear-to-send level
// RULE4: bit 0 flags cts change; irq unless auto-cts
// RULE5: auto-cts lets cts gate the transmitter
// RULE6: bit 7 dcd level, bit 3 change, interrupt
// RULE7: bit 5 dsr level, bit 1 change, interrupt
// RULE8: reading modem status clears change bits
// RULE9: data bus driven only during reads
// RULE10: transceiver off low except while reading
// RULE11: dtr low when bit set, high otherwise; the code holds dtr high while the loop bit is set
// RULE12: interrupt high for any enabled cause
// RULE13: interrupt drops when serviced or on reset
// RULE14: master reset clears registers, sets outputs
// RULE15: user pins low on bits 2, 3; the code holds them high while the loop bit is set
// RULE16: receiver clock sampled as sixteen-times clock
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module uhm_pins #(
	parameter int DATA_W = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic master_reset_in,
	input wire logic select_high_first,
	input wire logic select_high_second,
	input wire logic select_low_third,
	input wire logic address_latch_strobe_n,
	input wire uhm_pkg::uhm_bus_req_t bus_req,
	input wire uhm_pkg::uhm_modem_in_t modem_in,
	input wire logic rclk_16x,
	input wire logic rx_error_evt,
	input wire logic rx_data_evt,
	input wire logic rx_timeout_evt,
	input wire logic thr_empty_evt,
	input wire logic fifo_mode,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe_n,
	output logic transceiver_off,
	output logic irq,
	output logic dtr_n,
	output logic user_pin_one_n,
	output logic user_pin_two_n,
	output logic tx_allowed,
	output logic rx_sample_tick
);
	import uhm_pkg::*;

	if (DATA_W != 8) begin : g_width_check
		$error("uhm_pins serves an eight-bit data bus only");
	end

	function automatic logic reg_hit(input logic [2:0] a, input logic [2:0] off);
		return a == off;
	endfunction

	wire logic rst;
	wire logic sel_live;
	wire logic selected;
	wire logic [2:0] addr_eff;
	wire logic wr_hit;
	wire logic rd_hit;
	wire logic rd_msr;
	wire logic rd_irq;
	wire logic [2:0] lvl_now;
	wire logic [2:0] change;
	wire logic auto_cts;
	wire logic loop_on;
	wire logic modem_evt;
	wire logic [IRQ_W-1:0] events;
	wire logic [7:0] msr_val;
	wire logic [7:0] rd_mux;
	logic sel_hold_q;
	logic [2:0] addr_hold_q;
	logic [7:0] mcr_q, mcr_d;
	logic [IRQ_W-1:0] mask_q, mask_d;
	logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
	logic [2:0] lvl_q;
	logic [2:0] delta_q, delta_d;
	logic rclk_prev_q;
	logic [7:0] data_q;
	logic data_oe_n_q;
	logic xcvr_off_q;
	logic irq_q;
	logic dtr_n_q;
	logic user_pin_one_n_q;
	logic user_pin_two_n_q;
	logic tx_allowed_q;
	logic tick_q;

	// either reset clears the block
	assign rst = reset | master_reset_in; // RULE14

	assign sel_live = select_high_first & select_high_second & ~select_low_third; // RULE1
	// strobe tied low makes the selects transparent
	assign selected = address_latch_strobe_n ? sel_hold_q : sel_live; // RULE2
	assign addr_eff = address_latch_strobe_n ? addr_hold_q : bus_req.addr; // RULE2
	assign wr_hit = selected & bus_req.wr; // RULE1
	assign rd_hit = selected & bus_req.rd; // RULE1
	assign rd_msr = rd_hit & reg_hit(addr_eff, ADDR_MSR);
	assign rd_irq = rd_hit & reg_hit(addr_eff, ADDR_IRQ);

	always_ff @(posedge clk) begin
		if (rst) begin
			sel_hold_q <= 1'b0;
			addr_hold_q <= 3'h0;
		end else if (!address_latch_strobe_n) begin
			sel_hold_q <= sel_live; // RULE2
			addr_hold_q <= bus_req.addr;
		end
	end

	// control and mask registers
	assign auto_cts = mcr_q[MCR_ACTS];
	assign loop_on = mcr_q[MCR_LOOP];
	always_comb begin
		mcr_d = mcr_q;
		mask_d = mask_q;
		if (wr_hit && reg_hit(addr_eff, ADDR_MCR)) begin
			mcr_d = bus_req.wdata;
		end
		if (wr_hit && reg_hit(addr_eff, ADDR_MASK)) begin
			mask_d = bus_req.wdata[IRQ_W-1:0];
		end
	end

	// modem inputs are active low; status shows them asserted as one
	assign lvl_now = ~{modem_in.dcd_n, modem_in.dsr_n, modem_in.cts_n};
	assign change = lvl_now ^ lvl_q;
	// a change in the read cycle survives the clear
	always_comb begin
		delta_d = (delta_q & ~{3{rd_msr}}) | change; // RULE8
	end
	// cts changes stay silent while the transmitter is cts-gated
	assign modem_evt = change[2] | change[1] | (change[0] & ~auto_cts); // RULE4 RULE6 RULE7
	assign events = {modem_evt, thr_empty_evt, rx_timeout_evt & fifo_mode, rx_data_evt, rx_error_evt}; // RULE12
	always_comb begin
		irq_stat_d = (irq_stat_q & ~{IRQ_W{rd_irq}}) | events; // RULE13
	end

	assign msr_val = {lvl_now[2], 1'b0, lvl_now[1], lvl_now[0], delta_q[2], 1'b0, delta_q[1], delta_q[0]}; // RULE3 RULE6 RULE7
	assign rd_mux = reg_hit(addr_eff, ADDR_MSR) ? msr_val :
		reg_hit(addr_eff, ADDR_MCR) ? mcr_q :
		reg_hit(addr_eff, ADDR_IRQ) ? {3'h0, irq_stat_q} :
		reg_hit(addr_eff, ADDR_MASK) ? {3'h0, mask_q} : DATA_RST;

	always_ff @(posedge clk) begin
		if (rst) begin
			mcr_q <= MCR_RST;
			mask_q <= MASK_RST;
			irq_stat_q <= IRQ_RST;
			lvl_q <= 3'h0;
			delta_q <= 3'h0;
			rclk_prev_q <= 1'b0;
		end else begin
			mcr_q <= mcr_d;
			mask_q <= mask_d;
			irq_stat_q <= irq_stat_d;
			lvl_q <= lvl_now;
			delta_q <= delta_d; // RULE4 RULE6 RULE7
			rclk_prev_q <= rclk_16x;
		end
	end

	// pin outputs, all registered
	always_ff @(posedge clk) begin
		if (rst) begin
			data_q <= DATA_RST;
			data_oe_n_q <= 1'b1;
			xcvr_off_q <= 1'b0;
			irq_q <= 1'b0;
			dtr_n_q <= 1'b1;
			user_pin_one_n_q <= 1'b1;
			user_pin_two_n_q <= 1'b1;
			tx_allowed_q <= 1'b1;
			tick_q <= 1'b0;
		end else begin
			data_q <= rd_hit ? rd_mux : DATA_RST; // RULE9
			data_oe_n_q <= ~rd_hit; // RULE9
			xcvr_off_q <= rd_hit; // RULE10
			irq_q <= |(irq_stat_d & mask_d); // RULE12 RULE13
			dtr_n_q <= ~(mcr_d[MCR_DTR] & ~mcr_d[MCR_LOOP]); // RULE11
			user_pin_one_n_q <= ~(mcr_d[MCR_USER_PIN_ONE] & ~mcr_d[MCR_LOOP]); // RULE15
			user_pin_two_n_q <= ~(mcr_d[MCR_USER_PIN_TWO] & ~mcr_d[MCR_LOOP]); // RULE15
			tx_allowed_q <= ~mcr_d[MCR_ACTS] | lvl_now[0]; // RULE5
			// only the rising edge counts; rclk must be at most half of clk
			tick_q <= rclk_16x & ~rclk_prev_q; // RULE16
		end
	end

	assign data_out = data_q;
	assign data_oe_n = data_oe_n_q;
	assign transceiver_off = xcvr_off_q;
	assign irq = irq_q;
	assign dtr_n = dtr_n_q;
	assign user_pin_one_n = user_pin_one_n_q;
	assign user_pin_two_n = user_pin_two_n_q;
	assign tx_allowed = tx_allowed_q;
	assign rx_sample_tick = tick_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence strobe_held_s;
		address_latch_strobe_n ##1 address_latch_strobe_n;
	endsequence
	sequence rclk_rise_s;
		!rclk_16x ##1 rclk_16x;
	endsequence
	sequence msr_read_quiet_s;
		rd_msr && (change == 3'h0);
	endsequence
	sequence mcr_write_s;
		wr_hit && reg_hit(addr_eff, ADDR_MCR);
	endsequence
	sequence mask_write_s;
		wr_hit && reg_hit(addr_eff, ADDR_MASK);
	endsequence
	sequence read_then_idle_s;
		rd_hit ##1 !rd_hit;
	endsequence
	sequence strobe_rise_s;
		!address_latch_strobe_n ##1 address_latch_strobe_n;
	endsequence
	sequence msr_reread_s;
		msr_read_quiet_s ##1 (change == 3'h0) ##1 msr_read_quiet_s;
	endsequence
	sequence irq_service_s;
		irq ##1 (rd_irq && events == 5'h00);
	endsequence

	sel_gate_a: assert property ((bus_req.wr && !selected) |=> (mcr_q == $past(mcr_q))) // RULE1
		else $error("register changed while not selected");
	strobe_hold_a: assert property (strobe_held_s |-> (selected == $past(selected)) && (addr_eff == $past(addr_eff))) // RULE2
		else $error("select moved while strobe high");
	cts_level_a: assert property (rd_msr |=> (data_out[MSR_CTS] == $past(lvl_now[0]))) // RULE3
		else $error("cts level wrong in status read");
	cts_delta_a: assert property (change[0] |=> delta_q[0]) // RULE4
		else $error("cts change not flagged");
	auto_cts_irq_a: assert property ((auto_cts && change == 3'b001 && events[IRQ_MODEM-1:0] == 4'h0 && irq_stat_q == 5'h00) |=> !irq_stat_q[IRQ_MODEM]) // RULE4
		else $error("cts change raised interrupt under auto cts");
	tx_gate_a: assert property (mcr_d[MCR_ACTS] |=> (tx_allowed == $past(lvl_now[0]))) // RULE5
		else $error("transmitter not gated by cts");
	dcd_delta_a: assert property (change[2] |=> delta_q[2] ##0 irq_stat_q[IRQ_MODEM]) // RULE6
		else $error("dcd change not flagged");
	dsr_delta_a: assert property (change[1] |=> delta_q[1] ##0 irq_stat_q[IRQ_MODEM]) // RULE7
		else $error("dsr change not flagged");
	msr_clear_a: assert property (msr_read_quiet_s |=> (delta_q == 3'h0)) // RULE8
		else $error("change bits not cleared by read");
	bus_drive_a: assert property (!data_oe_n |-> $past(rd_hit)) // RULE9
		else $error("bus driven outside a read");
	xcvr_off_a: assert property (transceiver_off == !data_oe_n) // RULE10
		else $error("transceiver control out of step with reads");
	dtr_loop_a: assert property (loop_on |-> (dtr_n && user_pin_one_n && user_pin_two_n)) // RULE11
		else $error("dtr active in loopback");
	irq_level_a: assert property (irq == |(irq_stat_q & mask_q)) // RULE12
		else $error("interrupt output disagrees with causes");
	irq_service_a: assert property ((rd_irq && events == 5'h00) |=> !irq) // RULE13
		else $error("interrupt not dropped after service");
	mr_levels_a: assert property (@(posedge clk) disable iff (1'b0) master_reset_in |=> (dtr_n && user_pin_one_n && user_pin_two_n && !irq && data_oe_n)) // RULE14
		else $error("outputs not at reset levels");
	user_pin_a: assert property ((mcr_d[MCR_USER_PIN_ONE] && !mcr_d[MCR_LOOP]) |=> !user_pin_one_n) // RULE15
		else $error("user pin one not driven low");
	rclk_tick_a: assert property (rclk_rise_s |=> rx_sample_tick ##1 !rx_sample_tick) // RULE16
		else $error("receiver clock edge missed");
	mcr_store_a: assert property (mcr_write_s |=> (mcr_q == $past(bus_req.wdata))) // RULE11
		else $error("control register write lost");
	mask_store_a: assert property (mask_write_s |=> (mask_q == $past(bus_req.wdata[IRQ_W-1:0]))) // RULE12
		else $error("mask register write lost");
	mcr_pins_a: assert property (mcr_write_s |=> (dtr_n == !($past(bus_req.wdata[MCR_DTR]) && // RULE11
		!$past(bus_req.wdata[MCR_LOOP]))))
		else $error("dtr does not follow the written control bit");
	sel_mask_a: assert property ((bus_req.wr && !selected) |=> $stable(mask_q)) // RULE1
		else $error("mask changed while not selected");
	sel_read_a: assert property ((bus_req.rd && !selected) |=> data_oe_n) // RULE1
		else $error("bus driven for an unselected read");
	strobe_latch_a: assert property (strobe_rise_s |-> (selected == $past(sel_live)) && (addr_eff == $past(bus_req.addr))) // RULE2
		else $error("strobe rise did not latch the selects");
	mcr_read_a: assert property ((rd_hit && reg_hit(addr_eff, ADDR_MCR)) |=> (data_out == $past(mcr_q))) // RULE9
		else $error("control register read back wrong");
	mask_read_a: assert property ((rd_hit && reg_hit(addr_eff, ADDR_MASK)) |=> (data_out == {3'h0, $past(mask_q)})) // RULE9
		else $error("mask register read back wrong");
	idle_data_a: assert property (!rd_hit |=> (data_oe_n && (data_out == DATA_RST))) // RULE9
		else $error("data bus not idle without a read");
	read_turn_a: assert property (rd_hit |=> (!data_oe_n && transceiver_off)) // RULE10
		else $error("read did not turn the bus round");
	bus_release_a: assert property (read_then_idle_s |=> (data_oe_n && !transceiver_off)) // RULE10
		else $error("bus not released after a read");
	dsr_level_a: assert property (rd_msr |=> (data_out[MSR_DSR] == $past(lvl_now[1]))) // RULE7
		else $error("dsr level wrong in status read");
	dcd_level_a: assert property (rd_msr |=> (data_out[MSR_DCD] == $past(lvl_now[2]))) // RULE6
		else $error("dcd level wrong in status read");
	msr_delta_a: assert property (rd_msr |=> (data_out[MSR_DCTS] == $past(delta_q[0])) && // RULE8
		(data_out[MSR_DDSR] == $past(delta_q[1])) && (data_out[MSR_DDCD] == $past(delta_q[2])))
		else $error("change bits wrong in status read");
	msr_reread_a: assert property (msr_reread_s |=> (data_out[3:0] == 4'h0)) // RULE8
		else $error("change bits survived a quiet read");
	delta_hold_a: assert property ((!rd_msr && change == 3'h0) |=> $stable(delta_q)) // RULE8
		else $error("change bits moved without cause");
	cts_irq_a: assert property ((change[0] && !auto_cts) |=> irq_stat_q[IRQ_MODEM]) // RULE4
		else $error("cts change not raised as modem cause");
	rx_error_a: assert property (rx_error_evt |=> irq_stat_q[IRQ_RXERR]) // RULE12
		else $error("receiver error cause lost");
	rx_data_a: assert property (rx_data_evt |=> irq_stat_q[IRQ_RXDAT]) // RULE12
		else $error("received data cause lost");
	thr_empty_a: assert property (thr_empty_evt |=> irq_stat_q[IRQ_THRE]) // RULE12
		else $error("holding register empty cause lost");
	rx_timeout_a: assert property ((rx_timeout_evt && fifo_mode) |=> irq_stat_q[IRQ_RXTO]) // RULE12
		else $error("receive timeout cause lost");
	timeout_block_a: assert property ((rd_irq && !fifo_mode) |=> !irq_stat_q[IRQ_RXTO]) // RULE12
		else $error("receive timeout cause outside fifo mode");
	modem_irq_a: assert property ((modem_evt && mask_d[IRQ_MODEM]) |=> irq) // RULE12
		else $error("modem change did not interrupt");
	stat_sticky_a: assert property (!rd_irq |=> ((irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q))) // RULE13
		else $error("interrupt cause dropped without service");
	stat_clear_a: assert property ((rd_irq && events == 5'h00) |=> (irq_stat_q == 5'h00)) // RULE13
		else $error("interrupt causes not cleared by service");
	irq_read_a: assert property (rd_irq |=> (data_out[IRQ_W-1:0] == $past(irq_stat_q))) // RULE12
		else $error("interrupt status read back wrong");
	service_drop_a: assert property (irq_service_s |=> !irq) // RULE13
		else $error("pending interrupt not dropped by service");
	dtr_clear_a: assert property (!mcr_d[MCR_DTR] |=> dtr_n) // RULE11
		else $error("dtr active with its bit clear");
	user_two_a: assert property ((mcr_d[MCR_USER_PIN_TWO] && !mcr_d[MCR_LOOP]) |=> !user_pin_two_n) // RULE15
		else $error("user pin two not driven low");
	user_clear_a: assert property ((!mcr_d[MCR_USER_PIN_ONE] && !mcr_d[MCR_USER_PIN_TWO]) |=> (user_pin_one_n && user_pin_two_n)) // RULE15
		else $error("user pins active with bits clear");
	tx_free_a: assert property (!mcr_d[MCR_ACTS] |=> tx_allowed) // RULE5
		else $error("transmitter held without auto cts");
	tick_quiet_a: assert property (!(rclk_16x && !rclk_prev_q) |=> !rx_sample_tick) // RULE16
		else $error("sample tick without a receiver clock edge");
	tick_single_a: assert property (rx_sample_tick |=> !rx_sample_tick) // RULE16
		else $error("sample tick longer than one cycle");
	reset_levels_a: assert property (@(posedge clk) disable iff (1'b0) reset |=> (!transceiver_off && // RULE14
		tx_allowed && !rx_sample_tick && (data_out == DATA_RST)))
		else $error("outputs wrong after reset");
	mr_regs_a: assert property (@(posedge clk) disable iff (1'b0) master_reset_in |=> (mcr_q == MCR_RST && // RULE14
		mask_q == MASK_RST && irq_stat_q == IRQ_RST))
		else $error("registers not cleared by master reset");
endmodule
`default_nettype wire
